// [rtl/sro_pkg.sv]
`default_nettype none
package sro_pkg;

    localparam int WORD_W         = 16;
    localparam int BYTE_W         = 8;
    localparam int OS_W           = 3;
    localparam int ACC_W          = WORD_W + 6;
    localparam int BITCNT_W       = 4;
    localparam int TIMER_W        = 16;
    localparam int SAMPLECNT_W    = 7;
    localparam int NUM_CH_DEFAULT = 8;
    localparam int BYTES_PER_WORD = 2;

    localparam logic [OS_W-1:0]     OS_INVALID = 3'h7;
    localparam logic [BITCNT_W-1:0] MSB_IDX    = 4'hf;
    localparam logic [BITCNT_W-1:0] LAST_BIT   = 4'hf;

    // per-sample conversion time on the internal oscillator
    localparam int CLK_MHZ      = 125;
    localparam int T_CONV_NS    = 4000;
    localparam int CONV_CYCLES  = (T_CONV_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic
    {
        CV_IDLE,
        CV_RUN
    } sro_conv_state_type;

    // pin inputs, all asynchronous to clk
    typedef struct packed
    {
        logic            csN;
        logic            rdN;
        logic            sclk;
        logic            sampleStartA;
        logic            sampleStartB;
        logic            interfaceSelect;
        logic            byteModeSelect;
        logic            highByteFirst;
        logic [OS_W-1:0] oversampleRatioSel;
    } sro_pins_type;

    // ratio code to log2 of the averaging ratio; the invalid code averages nothing
    function automatic logic [OS_W-1:0] sro_os_shift(input logic [OS_W-1:0] code);
        sro_os_shift = (code == OS_INVALID) ? '0 : code;
    endfunction : sro_os_shift

endpackage : sro_pkg
`default_nettype wire

// [rtl/sro_readout.sv]
`timescale 1ns/10ps
`default_nettype none
// Contract
// - byte mode sends each result as two bytes; 2 strobes per channel.
// - byte mode when interface select and byte mode select both high.
// - byte mode drives only the low eight data lines, bit 0 is LSB.
// - high_byte_first high sends upper byte first, low sends lower first.
// - byte mode first-channel flag stays high until both bytes of channel one read.
// - serial output A starts with the first half, B with the second half.
// - chip select fall enables outputs with MSB; later bits shift on clock rise.
// - output B alone yields the rotated order, second half then first half.
// - serial flag floats with chip select high, high for channel one, low after 16th fall.
// - flag goes high only with channel one on output A.
// - reads while busy are allowed and return the previous results.
// - ratio select is captured at busy fall for the following conversion.
// - ratio select bit 2 is most significant, bit 0 least.
// - first sample at start edge, remaining N-1 internally, averaged to 16 bits.
// - busy time grows with the selected ratio.
// - successive read strobe falls step channels upward from channel one.
// - busy fall marks new results ready on every interface.
module sro_readout
#(
    parameter int NUM_CH   = sro_pkg::NUM_CH_DEFAULT,
    parameter int CONV_CYC = sro_pkg::CONV_CYCLES
)
(
    input  wire  logic                                   clk,
    input  wire  logic                                   arst_n,
    input  wire  sro_pkg::sro_pins_type                  pinsIn,
    input  wire  logic [NUM_CH-1:0][sro_pkg::WORD_W-1:0] rawData,
    output logic [sro_pkg::BYTE_W-1:0]                   dataOut,
    output logic                                         dataOe,
    output logic                                         serialOutA,
    output logic                                         serialOutB,
    output logic                                         serialOe,
    output logic                                         firstChannelFlag,
    output logic                                         firstFlagOe,
    output logic                                         busy,
    output logic                                         sampleHold
);
    import sro_pkg::*;

    localparam int CNT_W = $clog2(BYTES_PER_WORD * NUM_CH + 2);
    localparam logic [CNT_W-1:0] BYTE_END  = CNT_W'(BYTES_PER_WORD * NUM_CH);
    localparam logic [CNT_W-1:0] WORD_END  = CNT_W'(NUM_CH);
    localparam logic [CNT_W-1:0] HALF_CH   = CNT_W'(NUM_CH / 2);
    localparam logic [CNT_W-1:0] FIRST_END = CNT_W'(BYTES_PER_WORD);

    typedef struct packed
    {
        sro_pins_type                          p1;
        sro_pins_type                          p2;
        sro_pins_type                          p3;
        sro_conv_state_type                    conv;
        logic                                  seenA;
        logic                                  seenB;
        logic [OS_W-1:0]                       osLatched;
        logic [TIMER_W-1:0]                    timer;
        logic [SAMPLECNT_W-1:0]                sampleCnt;
        logic [NUM_CH-1:0][ACC_W-1:0]          acc;
        logic [NUM_CH-1:0][WORD_W-1:0]         results;
        logic [CNT_W-1:0]                      byteCnt;
        logic                                  byteFlag;
        logic [CNT_W-1:0]                      wordCnt;
        logic [BITCNT_W-1:0]                   bitCnt;
        logic [BYTE_W-1:0]                     dataOut;
        logic                                  dataOe;
        logic                                  outA;
        logic                                  outB;
        logic                                  serOe;
        logic                                  flag;
        logic                                  flagOe;
        logic                                  busy;
        logic                                  sampleHold;
    } sro_state_type;

    sro_state_type             st_reg;
    sro_state_type             st_next;
    logic [1:0]                rstSync_reg;
    logic                      rstN;
    logic signed [ACC_W-1:0]   sum;
    logic signed [ACC_W-1:0]   avg;
    logic                      byteMode;
    logic                      serMode;
    logic [CNT_W-1:0]          bIdx;
    logic                      byteHigh;
    logic [WORD_W-1:0]         byteWord;

    function automatic logic pick_bit(input logic [NUM_CH-1:0][WORD_W-1:0] res,
                                      input logic [CNT_W-1:0] idx,
                                      input logic [BITCNT_W-1:0] pos);
        pick_bit = (idx < WORD_END) ? res[idx][pos] : 1'b0;
    endfunction : pick_bit

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rstSync_reg <= 2'h0;
        else
            rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
    assign rstN = rstSync_reg[1];

    always_comb
    begin
        sum      = '0;
        avg      = '0;
        st_next  = st_reg;
        st_next.p1 = pinsIn;
        st_next.p2 = st_reg.p1;
        st_next.p3 = st_reg.p2;
        st_next.sampleHold = 1'b0;
        byteMode = st_reg.p2.interfaceSelect & st_reg.p2.byteModeSelect;
        serMode  = st_reg.p2.interfaceSelect & ~st_reg.p2.byteModeSelect;
        // output B runs half a frame ahead, wrapping round
        bIdx     = (st_reg.wordCnt + HALF_CH >= WORD_END) ? st_reg.wordCnt + HALF_CH - WORD_END
                                                         : st_reg.wordCnt + HALF_CH;
        byteHigh = st_reg.p2.highByteFirst ^ st_reg.byteCnt[0];
        byteWord = (st_reg.byteCnt < BYTE_END) ? st_reg.results[st_reg.byteCnt >> 1] : '0;

        st_next.dataOe = 1'b0;
        st_next.serOe  = 1'b0;
        st_next.flagOe = 1'b0;
        if (byteMode)
        begin
            if (!st_reg.p2.rdN && st_reg.p3.rdN && !st_reg.p2.csN)
            begin
                st_next.dataOut = byteHigh ? byteWord[WORD_W-1:BYTE_W] : byteWord[BYTE_W-1:0];
                if (st_reg.byteCnt <= BYTE_END)
                    st_next.byteCnt = st_reg.byteCnt + 1'b1;
            end
            if (st_reg.p2.rdN && !st_reg.p3.rdN && st_reg.byteCnt == FIRST_END)
                st_next.byteFlag = 1'b0;
            // judged on the count after this strobe, so a spare strobe never drives the lanes
            st_next.dataOe = !st_reg.p2.csN && !st_reg.p2.rdN && st_next.byteCnt != '0
                             && st_next.byteCnt <= BYTE_END;
            st_next.flagOe = 1'b1;
            st_next.flag   = st_next.byteFlag;
        end
        else if (serMode)
        begin
            st_next.serOe  = !st_reg.p2.csN && st_reg.wordCnt < WORD_END;
            st_next.flagOe = !st_reg.p2.csN;
            if (!st_reg.p2.csN && st_reg.p3.csN)
            begin
                st_next.outA  = pick_bit(st_reg.results, st_reg.wordCnt, MSB_IDX);
                st_next.outB  = pick_bit(st_reg.results, bIdx, MSB_IDX);
                st_next.flag  = (st_reg.wordCnt == '0);
            end
            else if (!st_reg.p2.csN && st_reg.p2.sclk && !st_reg.p3.sclk)
            begin
                st_next.outA  = pick_bit(st_reg.results, st_reg.wordCnt, MSB_IDX - st_reg.bitCnt);
                st_next.outB  = pick_bit(st_reg.results, bIdx, MSB_IDX - st_reg.bitCnt);
            end
            if (!st_reg.p2.csN && !st_reg.p2.sclk && st_reg.p3.sclk)
            begin
                st_next.bitCnt = st_reg.bitCnt + 1'b1;
                if (st_reg.bitCnt == LAST_BIT)
                begin
                    st_next.flag = 1'b0;
                    if (st_reg.wordCnt < WORD_END)
                        st_next.wordCnt = st_reg.wordCnt + 1'b1;
                end
            end
        end

        case (st_reg.conv)
            CV_IDLE:
            begin
                st_next.seenA = st_reg.seenA | (st_reg.p2.sampleStartA & ~st_reg.p3.sampleStartA);
                st_next.seenB = st_reg.seenB | (st_reg.p2.sampleStartB & ~st_reg.p3.sampleStartB);
                // busy rises on the later of the two start edges
                if (st_next.seenA && st_next.seenB)
                begin
                    st_next.conv       = CV_RUN;
                    st_next.busy       = 1'b1;
                    st_next.seenA      = 1'b0;
                    st_next.seenB      = 1'b0;
                    st_next.timer      = '0;
                    st_next.sampleCnt  = '0;
                    st_next.sampleHold = 1'b1;
                end
            end
            CV_RUN:
            begin
                st_next.timer = st_reg.timer + 1'b1;
                if (st_reg.timer == TIMER_W'(CONV_CYC - 1))
                begin
                    st_next.timer     = '0;
                    st_next.sampleCnt = st_reg.sampleCnt + 1'b1;
                    for (int i = 0; i < NUM_CH; i++)
                    begin
                        sum = $signed(st_reg.acc[i]) + ACC_W'($signed(rawData[i]));
                        avg = sum >>> sro_os_shift(st_reg.osLatched);
                        st_next.acc[i] = sum;
                        if (st_reg.sampleCnt == SAMPLECNT_W'((1 << sro_os_shift(st_reg.osLatched)) - 1))
                        begin
                            st_next.results[i] = avg[WORD_W-1:0];
                            st_next.acc[i]     = '0;
                        end
                    end
                    // ratio sets how many conversion slots busy spans
                    if (st_reg.sampleCnt == SAMPLECNT_W'((1 << sro_os_shift(st_reg.osLatched)) - 1))
                    begin
                        st_next.conv      = CV_IDLE;
                        st_next.busy      = 1'b0;
                        st_next.osLatched = st_reg.p2.oversampleRatioSel;
                        st_next.byteCnt   = '0;
                        st_next.byteFlag  = 1'b1;
                        st_next.wordCnt   = '0;
                        st_next.bitCnt    = '0;
                    end
                    else
                        st_next.sampleHold = 1'b1;
                end
            end
            default:
                st_next.conv = CV_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign dataOut          = st_reg.dataOut;
    assign dataOe           = st_reg.dataOe;
    assign serialOutA       = st_reg.outA;
    assign serialOutB       = st_reg.outB;
    assign serialOe         = st_reg.serOe;
    assign firstChannelFlag = st_reg.flag;
    assign firstFlagOe      = st_reg.flagOe;
    assign busy             = st_reg.busy;
    assign sampleHold       = st_reg.sampleHold;

    // busy length counter, read only by the checks below
    logic [31:0] busyCnt_reg;
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
            busyCnt_reg <= '0;
        else if (st_reg.busy)
            busyCnt_reg <= busyCnt_reg + 1'b1;
        else
            busyCnt_reg <= '0;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstN);

    os_latch_a: assert property ($fell(st_reg.busy) |-> st_reg.osLatched == $past(st_reg.p2.oversampleRatioSel))
        else $error("ratio select not captured at busy fall");
    busy_len_a: assert property ($fell(st_reg.busy) |->
                                 $past(busyCnt_reg) + 1 == CONV_CYC * (1 << sro_os_shift($past(st_reg.osLatched))))
        else $error("busy length does not match ratio");
    results_hold_a: assert property (st_reg.busy |-> $stable(st_reg.results))
        else $error("results changed while busy");
    serial_flag_a: assert property (serMode && !st_reg.p2.csN && st_reg.p3.csN
                                    |=> st_reg.flagOe && st_reg.flag == ($past(st_reg.wordCnt) == '0))
        else $error("flag wrong after chip select fall");
    flag_a_only_a: assert property (serMode && st_reg.flag && st_reg.flagOe |-> st_reg.wordCnt == '0)
        else $error("flag high away from channel one on output A");
    byte_oe_a: assert property (st_reg.dataOe |-> $past(byteMode) && !$past(st_reg.p2.rdN))
        else $error("byte lanes driven outside byte mode read");
    done_hiz_a: assert property (st_reg.byteCnt > BYTE_END |=> !st_reg.dataOe)
        else $error("data lanes driven after last byte");
    byte_step_a: assert property (byteMode && !st_reg.p2.rdN && st_reg.p3.rdN && !st_reg.p2.csN
                                  && st_reg.byteCnt < BYTE_END && st_reg.conv == CV_IDLE
                                  |=> st_reg.byteCnt == $past(st_reg.byteCnt) + 1'b1)
        else $error("read strobe did not step byte count");

    conv_cov: cover property ($rose(st_reg.busy) ##[1:1000] $fell(st_reg.busy));
    byte_cov: cover property (byteMode && st_reg.byteCnt == BYTE_END);
    serial_cov: cover property (serMode && st_reg.wordCnt == WORD_END);
endmodule : sro_readout
`default_nettype wire

// [verification/sro_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module sro_host_model
(
    input  wire logic        clk,
    input  wire logic [7:0]  dataOut,
    input  wire logic        dataOe,
    input  wire logic        serialOutA,
    input  wire logic        serialOutB,
    input  wire logic        serialOe,
    input  wire logic        firstChannelFlag,
    input  wire logic        firstFlagOe,
    output logic             hostCsN,
    output logic             hostRdN,
    output logic             hostSclk,
    output logic             gotValid,
    output logic [15:0]      gotWord
);
    logic [7:0] lastBus = 8'h00;
    logic       lastA   = 1'b0;
    logic       lastB   = 1'b0;
    logic       lastF   = 1'b0;
    logic       flagStart;
    logic       flagEnd;
    logic       flagRd;
    logic       oeStart;
    // released lines show the inverse of their last level, never a stale copy
    wire  [7:0] busSeen = dataOe ? dataOut : ~lastBus;
    wire        aSeen   = serialOe ? serialOutA : ~lastA;
    wire        bSeen   = serialOe ? serialOutB : ~lastB;
    wire        fSeen   = firstFlagOe ? firstChannelFlag : ~lastF;

    initial
    begin
        hostCsN  = 1'b1;
        hostRdN  = 1'b1;
        hostSclk = 1'b1;
        gotValid = 1'b0;
        gotWord  = 16'h0000;
    end

    always @(posedge clk)
    begin
        if (dataOe) lastBus <= dataOut;
        if (serialOe) lastA <= serialOutA;
        if (serialOe) lastB <= serialOutB;
        if (firstFlagOe) lastF <= firstChannelFlag;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    // chip select tied to the strobe, so each strobe frames one byte
    task automatic read_byte();
        hostCsN = 1'b0;
        hostRdN = 1'b0;
        wait_clk(6);
        gotWord = {8'h00, busSeen};
        flagRd  = fSeen;
        hostRdN = 1'b1;
        hostCsN = 1'b1;
        gotValid = 1'b1;
        wait_clk(1);
        gotValid = 1'b0;
        wait_clk(5);
    endtask : read_byte

    // clock idles high and stands still outside frames
    task automatic frame(input int words);
        logic [15:0] aw;
        logic [15:0] bw;
        hostCsN = 1'b0;
        wait_clk(10);
        flagStart = fSeen;
        oeStart   = serialOe;
        for (int w = 0; w < words; w++)
        begin
            for (int i = 0; i < 16; i++)
            begin
                aw = {aw[14:0], aSeen};
                bw = {bw[14:0], bSeen};
                hostSclk = 1'b0;
                wait_clk(10);
                flagEnd  = fSeen;
                hostSclk = 1'b1;
                wait_clk(10);
            end
            gotWord  = aw;
            gotValid = 1'b1;
            wait_clk(1);
            gotWord  = bw;
            wait_clk(1);
            gotValid = 1'b0;
        end
        hostCsN = 1'b1;
        wait_clk(10);
    endtask : frame
endmodule : sro_host_model
`default_nettype wire

// [verification/sro_readout_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module sro_readout_tb_top;
    import sro_pkg::*;
    localparam int NCH  = 8;
    localparam int CCYC = 8;
    logic                       clk    = 1'b0;
    logic                       arst_n = 1'b0;
    sro_pins_type               ctrl;
    sro_pins_type               pinsW;
    logic [NCH-1:0][WORD_W-1:0] raw;
    logic [BYTE_W-1:0]          dataOut;
    logic                       dataOe, serialOutA, serialOutB, serialOe;
    logic                       firstChannelFlag, firstFlagOe, busy, sampleHold;
    logic                       hostCsN, hostRdN, hostSclk, gotValid;
    logic [15:0]                gotWord;
    logic [15:0]                expQ[$];
    logic [31:0]                lfsr = 32'h00014a18;
    logic [OS_W-1:0]            prevCode;
    int                         failures = 0;
    int                         total_checks = 0;

    always #4 clk = ~clk;

    always_comb
    begin
        pinsW      = ctrl;
        pinsW.csN  = hostCsN;
        pinsW.rdN  = hostRdN;
        pinsW.sclk = hostSclk;
    end

    sro_readout #(.NUM_CH(NCH), .CONV_CYC(CCYC)) i_dut
    (
        .clk(clk), .arst_n(arst_n), .pinsIn(pinsW), .rawData(raw), .dataOut(dataOut),
        .dataOe(dataOe), .serialOutA(serialOutA), .serialOutB(serialOutB), .serialOe(serialOe),
        .firstChannelFlag(firstChannelFlag), .firstFlagOe(firstFlagOe), .busy(busy),
        .sampleHold(sampleHold)
    );

    sro_host_model i_host
    (
        .clk(clk), .dataOut(dataOut), .dataOe(dataOe), .serialOutA(serialOutA),
        .serialOutB(serialOutB), .serialOe(serialOe), .firstChannelFlag(firstChannelFlag),
        .firstFlagOe(firstFlagOe), .hostCsN(hostCsN), .hostRdN(hostRdN), .hostSclk(hostSclk),
        .gotValid(gotValid), .gotWord(gotWord)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        if (failures == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        lfsr_step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_step

    task automatic new_raw();
        for (int c = 0; c < NCH; c++)
        begin
            lfsr   = lfsr_step(lfsr);
            raw[c] = lfsr[15:0];
        end
    endtask : new_raw

    task automatic convert(input int ratio);
        int n;
        int h;
        n = 0;
        h = 0;
        ctrl.sampleStartA = 1'b1;
        ctrl.sampleStartB = 1'b1;
        for (int i = 0; i < 20 && busy !== 1'b1; i++) wait_clk(1);
        while (busy === 1'b1)
        begin
            n++;
            if (sampleHold === 1'b1) h++;
            wait_clk(1);
        end
        ctrl.sampleStartA = 1'b0;
        ctrl.sampleStartB = 1'b0;
        check(16'(n), 16'(CCYC * ratio));
        check(16'(h), 16'(ratio));
        wait_clk(5);
    endtask : convert

    task automatic byte_pass(input logic hbf, input int n);
        logic [7:0] e;
        ctrl.highByteFirst = hbf;
        new_raw();
        convert(1);
        for (int k = 0; k < n; k++)
        begin
            if (k < 2 * NCH) e = ((k % 2 == 0) == hbf) ? raw[k/2][15:8] : raw[k/2][7:0];
            else e = ~e;
            expQ.push_back({8'h00, e});
            i_host.read_byte();
            if (k < 3) check(16'(i_host.flagRd), 16'(k < 2));
        end
    endtask : byte_pass

    always @(posedge clk)
    begin
        if (gotValid === 1'b1)
            check(gotWord, expQ.pop_front());
    end

    initial
    begin
        ctrl     = '0;
        raw      = '0;
        prevCode = 3'h0;
        repeat (20) @(posedge clk);
        #1 arst_n = 1'b1;
        wait_clk(10);
        new_raw();
        for (int c = 0; c < 8; c++)
        begin
            ctrl.oversampleRatioSel = 3'(c);
            convert((prevCode == 3'h7) ? 1 : (1 << prevCode));
            prevCode = 3'(c);
        end
        ctrl.interfaceSelect = 1'b1;
        ctrl.byteModeSelect  = 1'b1;
        byte_pass(1'b1, 2 * NCH + 1);
        byte_pass(1'b0, 4);
        ctrl.byteModeSelect = 1'b0;
        new_raw();
        convert(1);
        for (int w = 0; w < NCH; w++)
        begin
            expQ.push_back(raw[w]);
            expQ.push_back(raw[(w + NCH / 2) % NCH]);
        end
        i_host.frame(4);
        check(16'(i_host.flagStart), 16'h0001);
        check(16'(i_host.flagEnd), 16'h0000);
        for (int w = 0; w < 4; w++)
        begin
            i_host.frame(1);
            check(16'(i_host.flagStart), 16'h0000);
        end
        i_host.frame(0);
        check(16'(i_host.oeStart), 16'h0000);
        check(16'(expQ.size()), 16'h0000);
        wait_clk(5);
        finish_test();
    end

    // whole run needs about 4100 cycles; this leaves ample margin
    initial
    begin
        #200000;
        failures++;
        finish_test();
    end
endmodule : sro_readout_tb_top
`default_nettype wire
